// ---- dwsp_pkg.sv ----
// constants and types of the dual waveform sample playback block
package dwsp_pkg;
    // ***************************************************************
    // memory geometry
    // ***************************************************************
    localparam int               ADDR_W    = 20;
    localparam int               LEN_W     = 21;
    localparam int               WORD_W    = 16;
    localparam int               SMP_W     = 14;
    localparam logic [LEN_W-1:0] MEM_DEPTH = 21'h100000;
    // ***************************************************************
    // waveform limits and sample codes
    // ***************************************************************
    localparam logic [LEN_W-1:0] MIN_LEN   = 21'h000010;
    localparam logic [SMP_W-1:0] ZERO_CODE = 14'h2000;
    localparam int               MK1_BIT   = 15;
    localparam int               MK2_BIT   = 14;
    // ***************************************************************
    // sequence table
    // ***************************************************************
    localparam int               SEG_N     = 4;
    localparam int               SEG_W     = 2;
    localparam logic             CHAN_I    = 1'b0;
    localparam logic             CHAN_Q    = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RUN     = 2'b01,
        ST_REFUSED = 2'b10
    } dwsp_state_e;
endpackage : dwsp_pkg

// ---- dwsp_mem_if.sv ----
// write and read signals between the sequencer and the waveform memory
`timescale 1ns/10ps
interface dwsp_mem_if;
    import dwsp_pkg::*;
    logic              wr_en;
    logic              wr_chan;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_i;
    logic [WORD_W-1:0] rd_q;
    modport ctl (output wr_en, wr_chan, wr_addr, wr_data, rd_addr, input rd_i, rd_q);
    modport mem (input wr_en, wr_chan, wr_addr, wr_data, rd_addr, output rd_i, rd_q);
endinterface : dwsp_mem_if

// ---- dwsp_wave_mem.sv ----
// waveform sample memory, one word array per channel, registered read
`timescale 1ns/10ps
module dwsp_wave_mem
    import dwsp_pkg::*;
(
    // clock
    input wire logic clk_in,
    // memory port
    dwsp_mem_if.mem  bus
);
    // ***************************************************************
    // storage
    // ***************************************************************
    logic [WORD_W-1:0] mem_i [int'(MEM_DEPTH)];
    logic [WORD_W-1:0] mem_q [int'(MEM_DEPTH)];
    logic [WORD_W-1:0] rd_i_q;
    logic [WORD_W-1:0] rd_q_q;

    always_ff @(posedge clk_in) begin
        if (bus.wr_en && bus.wr_chan == CHAN_I) begin
            mem_i[bus.wr_addr] <= bus.wr_data;
        end
        if (bus.wr_en && bus.wr_chan == CHAN_Q) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        rd_i_q <= mem_i[bus.rd_addr];
        rd_q_q <= mem_q[bus.rd_addr];
    end

    assign bus.rd_i = rd_i_q;
    assign bus.rd_q = rd_q_q;
endmodule : dwsp_wave_mem

// ---- dwsp_playback.sv ----
// dual waveform sample playback: loading, sequencing, markers and converter outputs
`timescale 1ns/10ps
// What this block does
// - memory holds up to 1,048,576 sixteen-bit words per channel, I and Q
// - segments shorter than 16 samples are refused and never played
// - segments with an odd sample count are refused
// - Q uses the I length, or Q is marked empty
// - low fourteen bits of each word go to the converter
// - I upper bits are markers; Q upper bits are ignored
// - samples are unsigned 0..16383, code 8192 is zero volts
// - marker one follows I bit 15, marker two I bit 14, per sample
// - with blanking enabled, active marker one blanks the RF output
// - each marker has its own polarity, chosen per segment
// - segment advance repeats a segment; trigger moves on after its end
// - each sample is held for exactly one clock period
module dwsp_playback
    import dwsp_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    // sample loading
    input  wire logic              load_valid_in,
    input  wire logic              load_chan_in,
    input  wire logic [ADDR_W-1:0] load_addr_in,
    input  wire logic [WORD_W-1:0] load_data_in,
    // sequence table
    input  wire logic [ADDR_W-1:0] seg_start_in    [SEG_N],
    input  wire logic [LEN_W-1:0]  seg_len_in      [SEG_N],
    input  wire logic [SEG_N-1:0]  seg_mk1_neg_in,
    input  wire logic [SEG_N-1:0]  seg_mk2_neg_in,
    input  wire logic [SEG_N-1:0]  seg_blank_en_in,
    input  wire logic [SEG_W-1:0]  seg_last_in,
    // play control
    input  wire logic              play_en_in,
    input  wire logic              seg_adv_mode_in,
    input  wire logic              q_empty_in,
    input  wire logic              trigger_in,
    // converter and marker outputs
    output logic      [SMP_W-1:0]  dac_i_out,
    output logic      [SMP_W-1:0]  dac_q_out,
    output logic                   marker1_out,
    output logic                   marker2_out,
    output logic                   rf_blank_out,
    // status
    output logic                   playing_out,
    output logic                   refused_out
);
    // ***************************************************************
    // memory and load path
    // ***************************************************************
    dwsp_mem_if mbus ();

    dwsp_wave_mem u_mem (
        .clk_in (clk_in),
        .bus    (mbus.mem)
    );

    assign mbus.wr_en   = load_valid_in;
    assign mbus.wr_chan = load_chan_in;
    assign mbus.wr_addr = load_addr_in;
    assign mbus.wr_data = load_data_in;

    // ***************************************************************
    // segment checks
    // ***************************************************************
    logic [SEG_N-1:0] seg_ok;
    logic [SEG_N-1:0] seg_used;
    wire              cfg_ok;

    for (genvar g = 0; g < SEG_N; g++) begin : g_seg
        wire [LEN_W:0] seg_end = {2'b00, seg_start_in[g]} + {1'b0, seg_len_in[g]};
        assign seg_used[g] = (SEG_W'(g) <= seg_last_in);
        assign seg_ok[g]   = (seg_len_in[g] >= MIN_LEN)
                           && !seg_len_in[g][0]
                           && (seg_end <= {1'b0, MEM_DEPTH});
    end
    assign cfg_ok = &(seg_ok | ~seg_used);

    // ***************************************************************
    // trigger synchroniser and pending flag
    // ***************************************************************
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic pend_q;
    logic pend_d;

    // ***************************************************************
    // sequencer
    // ***************************************************************
    dwsp_state_e      state_q;
    dwsp_state_e      state_d;
    logic [SEG_W-1:0] seg_q;
    logic [SEG_W-1:0] seg_d;
    logic [LEN_W-1:0] off_q;
    logic [LEN_W-1:0] off_d;

    wire              running  = (state_q == ST_RUN);
    wire [LEN_W-1:0]  cur_len  = seg_len_in[seg_q];
    wire              last     = (off_q == cur_len - LEN_W'(1));
    wire              at_end   = running && last;
    wire              may_adv  = seg_adv_mode_in ? pend_q : 1'b1;
    wire [SEG_W-1:0]  seg_nxt  = (seg_q == seg_last_in) ? '0 : seg_q + SEG_W'(1);
    wire              trig_rise = trig_s2_q && !trig_s3_q;
    wire              consume  = at_end && seg_adv_mode_in;

    assign pend_d = trig_rise || (pend_q && !consume && running);

    always_comb begin
        state_d = state_q;
        seg_d   = seg_q;
        off_d   = off_q;
        case (state_q)
            ST_IDLE: begin
                seg_d = '0;
                off_d = '0;
                if (play_en_in) begin
                    state_d = cfg_ok ? ST_RUN : ST_REFUSED;
                end
            end
            ST_RUN: begin
                off_d = last ? '0 : off_q + LEN_W'(1);
                if (last && may_adv) begin
                    seg_d = seg_nxt;
                end
                if (!play_en_in) begin
                    state_d = ST_IDLE;
                end
            end
            ST_REFUSED: begin
                if (!play_en_in) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign mbus.rd_addr = seg_start_in[seg_q] + off_q[ADDR_W-1:0];

    // ***************************************************************
    // output stage
    // ***************************************************************
    logic              v1_q;
    logic [SEG_W-1:0]  s1_q;
    wire  [WORD_W-1:0] wi       = mbus.rd_i;
    wire  [WORD_W-1:0] wq       = mbus.rd_q;
    wire               mk1_raw  = v1_q && wi[MK1_BIT];
    wire               mk2_raw  = v1_q && wi[MK2_BIT];
    wire [SMP_W-1:0]   smp_i    = v1_q ? wi[SMP_W-1:0] : ZERO_CODE;
    wire [SMP_W-1:0]   smp_q    = (v1_q && !q_empty_in) ? wq[SMP_W-1:0] : ZERO_CODE;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            pend_q    <= 1'b0;
            state_q   <= ST_IDLE;
            seg_q     <= '0;
            off_q     <= '0;
            v1_q      <= 1'b0;
            s1_q      <= '0;
        end else begin
            trig_s1_q <= trigger_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            pend_q    <= pend_d;
            state_q   <= state_d;
            seg_q     <= seg_d;
            off_q     <= off_d;
            v1_q      <= running;
            s1_q      <= seg_q;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dac_i_out    <= ZERO_CODE;
            dac_q_out    <= ZERO_CODE;
            marker1_out  <= 1'b0;
            marker2_out  <= 1'b0;
            rf_blank_out <= 1'b0;
        end else begin
            dac_i_out    <= smp_i;
            dac_q_out    <= smp_q;
            marker1_out  <= mk1_raw ^ seg_mk1_neg_in[s1_q];
            marker2_out  <= mk2_raw ^ seg_mk2_neg_in[s1_q];
            rf_blank_out <= mk1_raw && seg_blank_en_in[s1_q];
        end
    end

    assign playing_out = running;
    assign refused_out = (state_q == ST_REFUSED);

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    AST_ADDR_IN_RANGE: assert property (
        running |-> (({2'b00, seg_start_in[seg_q]} + {1'b0, off_q}) < {1'b0, MEM_DEPTH}))
        else $error("read address outside waveform memory");
    AST_SHORT_REFUSED: assert property (
        state_q == ST_IDLE && play_en_in && seg_len_in[0] < MIN_LEN |=> state_q == ST_REFUSED)
        else $error("short segment was not refused");
    AST_ODD_NEVER_PLAYS: assert property (
        running |-> !cur_len[0])
        else $error("odd length segment is playing");
    AST_SAMPLE_PATH: assert property (
        running ##1 v1_q |=> dac_i_out == $past(wi[SMP_W-1:0]))
        else $error("converter I value differs from memory sample");
    AST_Q_BITS_IGNORED: assert property (
        v1_q && !q_empty_in |=> dac_q_out == $past(wq[SMP_W-1:0]))
        else $error("Q upper bits reached converter");
    AST_IDLE_ZERO: assert property (
        !v1_q |=> dac_i_out == ZERO_CODE && dac_q_out == ZERO_CODE)
        else $error("idle output is not the zero-volt code");
    AST_MARKER1: assert property (
        v1_q |=> marker1_out == ($past(wi[MK1_BIT]) ^ seg_mk1_neg_in[$past(s1_q)]))
        else $error("marker one does not follow bit 15");
    AST_MARKER2: assert property (
        v1_q |=> marker2_out == ($past(wi[MK2_BIT]) ^ seg_mk2_neg_in[$past(s1_q)]))
        else $error("marker two does not follow bit 14 and polarity");
    AST_BLANK: assert property (
        v1_q && wi[MK1_BIT] && seg_blank_en_in[s1_q] |=> rf_blank_out)
        else $error("RF not blanked during marker one");
    AST_SEG_REPEAT: assert property (
        at_end && seg_adv_mode_in && !pend_q && play_en_in |=> running && seg_q == $past(seg_q) && off_q == '0)
        else $error("segment advanced without trigger");
    AST_WRAP_NO_IDLE: assert property (
        at_end && play_en_in |=> running && off_q == '0)
        else $error("idle cycle at waveform wrap");
    AST_Q_EMPTY: assert property (
        q_empty_in [*2] |-> dac_q_out == ZERO_CODE)
        else $error("empty Q not at zero-volt code");

    COV_WRAP:    cover property (at_end ##1 running ##1 running);
    COV_ADVANCE: cover property (at_end && seg_adv_mode_in && pend_q ##1 seg_q != $past(seg_q));
    COV_REFUSE:  cover property (state_q == ST_REFUSED);
    COV_BLANK:   cover property (rf_blank_out);
endmodule : dwsp_playback

// ---- dwsp_dac_model.sv ----
// behavioural model of the two sample converters
`timescale 1ns/10ps
module dwsp_dac_model
    import dwsp_pkg::*;
(
    // clock
    input  wire logic             clk_in,
    // converter codes
    input  wire logic [SMP_W-1:0] dac_i_in,
    input  wire logic [SMP_W-1:0] dac_q_in,
    // held output levels
    output logic      [SMP_W-1:0] hold_i_out,
    output logic      [SMP_W-1:0] hold_q_out
);
    // ****************************************
    // sample and hold, one period per code
    // ****************************************
    always_ff @(posedge clk_in) begin
        hold_i_out <= dac_i_in;
        hold_q_out <= dac_q_in;
    end
endmodule : dwsp_dac_model

// ---- tb_dual_waveform_sample_playback.sv ----
// self-checking bench of the playback block
`timescale 1ns/10ps
module tb_dual_waveform_sample_playback;
    import dwsp_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic              clk = 1'b0, rstn = 1'b0, lv = 1'b0, lc = 1'b0, pe = 1'b0, qe = 1'b0;
    logic [ADDR_W-1:0] la = '0;
    logic [WORD_W-1:0] ld = '0;
    logic [ADDR_W-1:0] st [SEG_N] = '{default: '0};
    logic [LEN_W-1:0]  sl [SEG_N] = '{default: MIN_LEN};
    logic [SEG_N-1:0]  n1 = '0, n2 = '0, be = '0;
    logic [SEG_W-1:0]  sg = '0;
    logic              am = 1'b0, tr = 1'b0;
    logic [SMP_W-1:0]  di, dq, hi, hq;
    logic              m1, m2, rb, pl, rf;
    int                failures = 0, samples_checked = 0, cyc = 0;
    always #10 clk = ~clk;
    dwsp_playback uut (.clk_in(clk), .rstn_in(rstn), .load_valid_in(lv), .load_chan_in(lc), .load_addr_in(la),
        .load_data_in(ld), .seg_start_in(st), .seg_len_in(sl), .seg_mk1_neg_in(n1), .seg_mk2_neg_in(n2),
        .seg_blank_en_in(be), .seg_last_in(sg), .play_en_in(pe), .seg_adv_mode_in(am), .q_empty_in(qe),
        .trigger_in(tr), .dac_i_out(di), .dac_q_out(dq), .marker1_out(m1), .marker2_out(m2),
        .rf_blank_out(rb), .playing_out(pl), .refused_out(rf));
    dwsp_dac_model dac (.clk_in(clk), .dac_i_in(di), .dac_q_in(dq), .hold_i_out(hi), .hold_q_out(hq));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk_smp(input logic [SMP_W-1:0] got, input logic [SMP_W-1:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk_smp
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask : chk_bit
    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            test_done();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    function automatic logic [SMP_W-1:0] smp(input int k);
        return ZERO_CODE - 14'h0800 + SMP_W'(k * 16'h0101);
    endfunction : smp
    task automatic load_all;
        for (int k = 0; k < 32; k++) begin
            lv = 1'b1;
            lc = k[4];
            la = ADDR_W'(k % 16);
            ld = lc ? {2'h3, 14'h3FFF - smp(k % 16)} : {k[0], k[1], smp(k)};
            @(negedge clk);
        end
        lv = 1'b0;
    endtask : load_all
    task automatic run_play(input logic neg);
        logic [SMP_W-1:0] pi;
        logic [SMP_W-1:0] pq;
        int               k;
        n1 = {SEG_N{neg}};
        n2 = {SEG_N{neg}};
        be = {SEG_N{neg}};
        qe = neg;
        pe = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit(pl, 1'b1, "playing");
        for (int j = 0; j < 32; j++) begin
            k = j % 16;
            chk_smp(di, smp(k), "dac i");
            chk_smp(dq, neg ? ZERO_CODE : 14'h3FFF - smp(k), "dac q");
            chk_bit(m1, k[0] ^ neg, "marker one");
            chk_bit(m2, k[1] ^ neg, "marker two");
            chk_bit(rb, k[0] & neg, "blank");
            if (j > 0) chk_smp(hi, pi, "held i");
            if (j > 0) chk_smp(hq, pq, "held q");
            pi = smp(k);
            pq = neg ? ZERO_CODE : 14'h3FFF - smp(k);
            @(negedge clk);
        end
        pe = 1'b0;
        repeat (3) @(negedge clk);
    endtask : run_play
    task automatic run_refuse(input logic [ADDR_W-1:0] start, input logic [LEN_W-1:0] len);
        st[0] = start;
        sl[0] = len;
        pe = 1'b1;
        repeat (5) @(negedge clk);
        chk_bit(rf, 1'b1, "refused");
        chk_bit(pl, 1'b0, "not playing");
        chk_smp(di, ZERO_CODE, "refused dac i");
        pe = 1'b0;
        st[0] = '0;
        sl[0] = MIN_LEN;
        repeat (3) @(negedge clk);
    endtask : run_refuse
    task automatic run_advance;
        int               k;
        n1 = 4'h2;
        n2 = '0;
        be = '0;
        qe = 1'b0;
        sg = 2'h1;
        am = 1'b1;
        pe = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (int j = 0; j < 48; j++) begin
            k = j % 16;
            tr = (j < 4);
            chk_smp(di, smp(k), "advance dac i");
            chk_bit(m1, k[0] ^ (j >= 16), "segment marker one");
            @(negedge clk);
        end
        pe = 1'b0;
        am = 1'b0;
        sg = 2'h0;
        repeat (3) @(negedge clk);
    endtask : run_advance
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk_smp(di, ZERO_CODE, "idle dac i");
        chk_bit(pl, 1'b0, "idle");
        load_all();
        run_play(1'b0);
        run_play(1'b1);
        run_refuse('0, 21'h00000E);
        run_refuse('0, 21'h000011);
        run_refuse(20'hFFFF8, MIN_LEN);
        run_advance();
        run_play(1'b0);
        test_done();
    end
endmodule : tb_dual_waveform_sample_playback
